// ---- design/clk_ctl_pkg.sv ----
// Constants shared by the clock prescale and sleep control block.
// Assumes a 32-bit classic Wishbone register bus and a 50 MHz clock.
package clk_ctl_pkg;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [3:0] OFS_TRIM   = 4'h0;
    localparam logic [3:0] OFS_DIVCTL = 4'h4;
    localparam logic [3:0] OFS_PCTL   = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;

    // ========================================================
    // Field positions
    localparam int UNLOCK_BIT   = 7;
    localparam int SE_BIT       = 0;
    localparam int SM_LSB       = 1;
    localparam logic [7:0] UNLOCK_PATTERN = 8'h80;

    // ========================================================
    // Reset values and encodings
    localparam logic [3:0] DIVSEL_RST_PLAIN = 4'h0;
    localparam logic [3:0] DIVSEL_RST_FUSE  = 4'h3;
    localparam logic [3:0] DIVSEL_MAX       = 4'h8;
    localparam logic [1:0] SM_IDLE          = 2'h0;
    localparam logic [1:0] SM_ADCNR         = 2'h1;
    localparam logic [1:0] SM_PDOWN         = 2'h2;

    // ========================================================
    // Cycle counts
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0] WAKE_HOLD_CYC = 3'h4;

    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_START = 4'b0100,
        ST_HOLD  = 4'b1000
    } state_t;

endpackage

// ---- design/clock_prescale_sleep_control.sv ----
// Clock trim, system clock prescaler and sleep-mode clock gating.
// Assumes a classic Wishbone master and a core that pulses sleep_instr_i.
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
module clock_prescale_sleep_control #(
    parameter int unsigned STARTUP_CYC = 16
) (
    input  wire logic        clk_i,          // Master clock, 50 MHz
    input  wire logic        rst_i,          // Chip reset, sync, high
    input  wire logic        cyc_i,          // Wishbone cycle
    input  wire logic        stb_i,          // Wishbone strobe
    input  wire logic        we_i,           // Wishbone write
    input  wire logic [3:0]  adr_i,          // Wishbone byte address
    input  wire logic [3:0]  sel_i,          // Wishbone byte enables
    input  wire logic [31:0] dat_i,          // Wishbone write data
    output logic      [31:0] dat_o,          // Wishbone read data
    output logic             ack_o,          // Wishbone acknowledge
    input  wire logic [7:0]  factory_trim_i, // Factory trim value
    input  wire logic        div8_fuse_i,    // Divide-by-eight fuse
    input  wire logic        legacy_mode_i,  // Legacy compatibility mode
    input  wire logic        sleep_instr_i,  // Sleep instruction pulse
    input  wire logic        adc_enabled_i,  // ADC is enabled
    input  wire logic        any_irq_i,      // Any enabled interrupt
    input  wire logic        irq0_level_i,   // external_irq_line0 level
    input  wire logic        pin_change_i,   // Pin change interrupt
    input  wire logic        mem_ready_i,    // Memory-ready interrupt
    input  wire logic        start_cond_i,   // Serial start condition
    input  wire logic        adc_done_i,     // ADC conversion complete
    input  wire logic        wdt_irq_i,      // Watchdog interrupt
    output logic      [7:0]  osc_trim_o,     // Trim to the RC oscillator
    output logic             sys_tick_o,     // Divided system clock tick
    output logic             clk_cpu_en_o,   // CPU clock enable
    output logic             clk_flash_en_o, // Flash clock enable
    output logic             clk_io_en_o,    // I/O clock enable
    output logic             clk_adc_en_o,   // ADC clock enable
    output logic             clk_pll_en_o,   // PLL peripheral clock enable
    output logic             main_osc_en_o,  // Main clock source enable
    output logic             cpu_hold_o,     // Core halted
    output logic             wake_o,         // Wake-up pulse to core
    output logic             adc_start_o     // ADC start pulse
);

    // ========================================================
    // Helpers
    function automatic logic [7:0] div_mask(input logic [3:0] code);
        logic [3:0] c;
        c = (code > clk_ctl_pkg::DIVSEL_MAX) ? clk_ctl_pkg::DIVSEL_MAX
                                             : code;
        div_mask = (c == 4'h8) ? 8'hff : 8'((9'h001 << c) - 9'h001);
    endfunction

    function automatic logic wake_src(input logic [1:0] sm,
                                      input logic [6:0] src);
        wake_src = 1'b0;
        case (sm)
            clk_ctl_pkg::SM_IDLE:  wake_src = src[0];
            clk_ctl_pkg::SM_ADCNR: wake_src = |src[6:1];
            clk_ctl_pkg::SM_PDOWN: wake_src = src[1] | src[2] | src[4]
                                            | src[6];
            default:               wake_src = 1'b0;
        endcase
    endfunction

    localparam logic [7:0] STARTUP_LAST = 8'(STARTUP_CYC - 1);

    // ========================================================
    // Wishbone slave: ack one cycle after the request, write on ack edge
    logic        ack_q;
    logic        req;
    logic        wr_trim;
    logic        wr_div;
    logic        wr_pctl;
    logic [7:0]  wdat;
    logic [7:0]  trim_q;
    logic [3:0]  divsel_q;
    logic        unlock_q;
    logic [2:0]  unlock_cnt_q;
    logic        se_q;
    logic [1:0]  sm_q;
    logic [31:0] rdat;
    logic [3:0]  act_code_q;
    clk_ctl_pkg::state_t state_q, state_d;

    assign req  = cyc_i & stb_i;
    assign wdat = dat_i[7:0];
    assign wr_trim = req & we_i & ack_q & sel_i[0]
                   & (adr_i == clk_ctl_pkg::OFS_TRIM);
    assign wr_div  = req & we_i & ack_q & sel_i[0]
                   & (adr_i == clk_ctl_pkg::OFS_DIVCTL);
    assign wr_pctl = req & we_i & ack_q & sel_i[0]
                   & (adr_i == clk_ctl_pkg::OFS_PCTL);

    always_comb begin
        rdat = 32'h0000_0000;
        if (adr_i == clk_ctl_pkg::OFS_TRIM) begin
            rdat[7:0] = trim_q;
        end else if (adr_i == clk_ctl_pkg::OFS_DIVCTL) begin
            rdat[7:0] = {unlock_q, 3'b000, divsel_q};
        end else if (adr_i == clk_ctl_pkg::OFS_PCTL) begin
            rdat[clk_ctl_pkg::SE_BIT]      = se_q;
            rdat[clk_ctl_pkg::SM_LSB +: 2] = sm_q;
        end else if (adr_i == clk_ctl_pkg::OFS_STATUS) begin
            rdat[3:0] = state_q;
            rdat[7:4] = act_code_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q & ~we_i) begin
                dat_o <= rdat;
            end
        end
    end
    assign ack_o = ack_q;

    // ========================================================
    // Oscillator trim: bit 7 picks the range, bits 6:0 tune inside it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_q <= factory_trim_i;
        end else if (wr_trim) begin
            trim_q <= wdat;
        end
    end
    assign osc_trim_o = trim_q;

    // ========================================================
    // Divider unlock window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_q     <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (wr_div & ~wdat[clk_ctl_pkg::UNLOCK_BIT]) begin
            unlock_q     <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (unlock_q) begin
            // A second unlock write here does not restart the count
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
            if (unlock_cnt_q == 3'h1) begin
                unlock_q <= 1'b0;
            end
        end else if (wr_div & (wdat == clk_ctl_pkg::UNLOCK_PATTERN)) begin
            unlock_q     <= 1'b1;
            unlock_cnt_q <= clk_ctl_pkg::UNLOCK_CYCLES;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divsel_q <= div8_fuse_i ? clk_ctl_pkg::DIVSEL_RST_FUSE
                                    : clk_ctl_pkg::DIVSEL_RST_PLAIN;
        end else if (wr_div & unlock_q & ~wdat[clk_ctl_pkg::UNLOCK_BIT]
                     & ~legacy_mode_i) begin
            divsel_q <= wdat[3:0];
        end
    end

    // ========================================================
    // Prescaler: new code lands only when the running period ends
    logic [7:0] div_cnt_q;
    logic [3:0] eff_code;
    logic       wrap;

    assign eff_code = legacy_mode_i ? 4'h0 : divsel_q;
    assign wrap     = (div_cnt_q == div_mask(act_code_q));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_q  <= 8'h00;
            act_code_q <= 4'h0;
            sys_tick_o <= 1'b0;
        end else begin
            sys_tick_o <= wrap;
            if (wrap) begin
                div_cnt_q  <= 8'h00;
                act_code_q <= eff_code;
            end else begin
                div_cnt_q  <= div_cnt_q + 8'h01;
            end
        end
    end

    // ========================================================
    // Sleep control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            se_q <= 1'b0;
            sm_q <= clk_ctl_pkg::SM_IDLE;
        end else if (wr_pctl) begin
            se_q <= wdat[clk_ctl_pkg::SE_BIT];
            sm_q <= wdat[clk_ctl_pkg::SM_LSB +: 2];
        end
    end

    // ========================================================
    // Sleep state machine; reset returns to run from any state
    logic [1:0] mode_q;
    logic [7:0] cnt_q;
    logic       wake;
    logic       enter;

    assign wake  = wake_src(mode_q, {wdt_irq_i, adc_done_i, start_cond_i,
                                     mem_ready_i, pin_change_i,
                                     irq0_level_i, any_irq_i});
    assign enter = sleep_instr_i & se_q & (sm_q != 2'h3);

    always_comb begin
        state_d = state_q;
        case (state_q)
            clk_ctl_pkg::ST_RUN: begin
                if (enter) begin
                    state_d = clk_ctl_pkg::ST_SLEEP;
                end
            end
            clk_ctl_pkg::ST_SLEEP: begin
                if (wake) begin
                    state_d = (mode_q == clk_ctl_pkg::SM_PDOWN)
                            ? clk_ctl_pkg::ST_START
                            : clk_ctl_pkg::ST_HOLD;
                end
            end
            clk_ctl_pkg::ST_START: begin
                if (cnt_q == STARTUP_LAST) begin
                    state_d = clk_ctl_pkg::ST_HOLD;
                end
            end
            clk_ctl_pkg::ST_HOLD: begin
                if (cnt_q == 8'(clk_ctl_pkg::WAKE_HOLD_CYC - 3'h1)) begin
                    state_d = clk_ctl_pkg::ST_RUN;
                end
            end
            default: state_d = clk_ctl_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= clk_ctl_pkg::ST_RUN;
            mode_q  <= clk_ctl_pkg::SM_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
            if (state_q == clk_ctl_pkg::ST_RUN && enter) begin
                mode_q <= sm_q;
            end
        end
    end

    // ========================================================
    // Clock gating, registered against the next state so it lines up
    // with state_q; memory contents are untouched, clocks only stop
    logic sl_d;
    logic md_idle;
    logic md_adc;
    logic [1:0] mode_d;

    assign mode_d  = (state_q == clk_ctl_pkg::ST_RUN) ? sm_q : mode_q;
    assign sl_d    = (state_d == clk_ctl_pkg::ST_SLEEP);
    assign md_idle = (mode_d == clk_ctl_pkg::SM_IDLE);
    assign md_adc  = (mode_d == clk_ctl_pkg::SM_ADCNR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_cpu_en_o   <= 1'b1;
            clk_flash_en_o <= 1'b1;
            clk_io_en_o    <= 1'b1;
            clk_adc_en_o   <= 1'b1;
            clk_pll_en_o   <= 1'b1;
            main_osc_en_o  <= 1'b1;
            cpu_hold_o     <= 1'b0;
        end else begin
            clk_cpu_en_o   <= ~sl_d;
            clk_flash_en_o <= ~sl_d;
            clk_io_en_o    <= ~sl_d | md_idle;
            clk_adc_en_o   <= ~sl_d | md_idle | md_adc;
            clk_pll_en_o   <= ~sl_d | md_idle;
            main_osc_en_o  <= ~sl_d | md_idle | md_adc;
            cpu_hold_o     <= (state_d != clk_ctl_pkg::ST_RUN);
        end
    end

    // ========================================================
    // Event pulses to the core and the ADC
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o      <= 1'b0;
            adc_start_o <= 1'b0;
        end else begin
            wake_o      <= (state_q == clk_ctl_pkg::ST_HOLD)
                         & (state_d == clk_ctl_pkg::ST_RUN);
            adc_start_o <= (state_q == clk_ctl_pkg::ST_RUN) & enter
                         & adc_enabled_i
                         & (sm_q != clk_ctl_pkg::SM_PDOWN);
        end
    end

    // ========================================================
    // Assertions
    AST_TRIM_RESET: assert property (@(posedge clk_i)
        $past(rst_i) && !rst_i |-> trim_q == $past(factory_trim_i))
        else $error("trim not loaded at reset");
    AST_UNLOCK_ONLY_CLEAN: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_div && !unlock_q && wdat != clk_ctl_pkg::UNLOCK_PATTERN
        |=> !unlock_q)
        else $error("unlock set by unclean write");
    AST_UNLOCK_TIMEOUT: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(unlock_q) |-> ##4 !unlock_q)
        else $error("unlock window not four cycles");
    AST_DIV_LOCKED: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !(wr_div && unlock_q && !wdat[7]) |=> $stable(divsel_q))
        else $error("divider changed without unlock");
    AST_DIV_TAKEN: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_div && unlock_q && !wdat[7] && !legacy_mode_i
        |=> divsel_q == $past(wdat[3:0]) && !unlock_q)
        else $error("divider write lost");
    AST_RES_ZERO: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ack_o && !we_i && adr_i == clk_ctl_pkg::OFS_DIVCTL
        |-> dat_o[6:4] == 3'b000)
        else $error("reserved bits read nonzero");
    AST_IDLE_GATES: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_q == clk_ctl_pkg::ST_SLEEP && mode_q == clk_ctl_pkg::SM_IDLE
        |-> !clk_cpu_en_o && !clk_flash_en_o && clk_io_en_o
            && clk_adc_en_o && clk_pll_en_o && main_osc_en_o)
        else $error("idle gating wrong");
    AST_PD_GATES: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_q == clk_ctl_pkg::ST_SLEEP && mode_q == clk_ctl_pkg::SM_PDOWN
        |-> !clk_io_en_o && !clk_adc_en_o && !main_osc_en_o)
        else $error("power-down gating wrong");
    AST_NO_SLEEP_SE0: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_q == clk_ctl_pkg::ST_RUN && sleep_instr_i && !se_q
        |=> state_q == clk_ctl_pkg::ST_RUN && clk_cpu_en_o)
        else $error("slept with sleep enable clear");
    AST_HOLD_FOUR: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(state_q == clk_ctl_pkg::ST_HOLD)
        |-> (cpu_hold_o)[*4] ##1 !cpu_hold_o && wake_o)
        else $error("wake hold not four cycles");
    AST_ADC_START: assert property (@(posedge clk_i)
        disable iff (rst_i)
        state_q == clk_ctl_pkg::ST_RUN && enter && adc_enabled_i
        && sm_q == clk_ctl_pkg::SM_IDLE |=> adc_start_o)
        else $error("no ADC start on idle entry");
    COV_IDLE: cover property (@(posedge clk_i) disable iff (rst_i)
        state_q == clk_ctl_pkg::ST_SLEEP && mode_q == clk_ctl_pkg::SM_IDLE
        ##1 state_q == clk_ctl_pkg::ST_HOLD);
    COV_PDOWN: cover property (@(posedge clk_i) disable iff (rst_i)
        state_q == clk_ctl_pkg::ST_START ##1 state_q == clk_ctl_pkg::ST_START);
    COV_DIV_CHANGE: cover property (@(posedge clk_i) disable iff (rst_i)
        $changed(divsel_q));

endmodule

// ---- dv/clock_prescale_sleep_control_tb.sv ----
// Self-checking bench for the clock prescale and sleep control block.
// Assumes the partner model in core_model.sv drives the core inputs.
`timescale 1ns/100ps
module clock_prescale_sleep_control_tb;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [3:0]  adr_i = 0, sel_i = 0, c;
    logic [31:0] dat_i = 0, dat_o, d;
    logic [7:0]  factory_trim_i = 0, osc_trim_o, t;
    logic        div8_fuse_i = 1, legacy_mode_i = 0, adc_enabled_i = 1;
    logic        sreq = 0, wreq = 0, instr, ack_o, sys_tick_o, cpu_hold_o;
    logic        wake_o, adc_start_o;
    logic [6:0]  wmask = 0, src;
    wire  [5:0]  en;
    integer      seed = 13;
    int          error_cnt = 0, checks = 0, i, n, st, adc_cnt = 0;
    clock_prescale_sleep_control #(.STARTUP_CYC(2)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .factory_trim_i(factory_trim_i),
        .div8_fuse_i(div8_fuse_i), .legacy_mode_i(legacy_mode_i),
        .sleep_instr_i(instr), .adc_enabled_i(adc_enabled_i),
        .any_irq_i(src[0]), .irq0_level_i(src[1]), .pin_change_i(src[2]),
        .mem_ready_i(src[3]), .start_cond_i(src[4]), .adc_done_i(src[5]),
        .wdt_irq_i(src[6]), .osc_trim_o(osc_trim_o),
        .sys_tick_o(sys_tick_o), .clk_cpu_en_o(en[5]),
        .clk_flash_en_o(en[4]), .clk_io_en_o(en[3]), .clk_adc_en_o(en[2]),
        .clk_pll_en_o(en[1]), .main_osc_en_o(en[0]),
        .cpu_hold_o(cpu_hold_o), .wake_o(wake_o), .adc_start_o(adc_start_o));
    core_model core (.clk_i(clk_i), .sleep_i(sreq), .wake_i(wreq),
        .mask_i(wmask), .hold_i(cpu_hold_o), .instr_o(instr), .src_o(src));
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (adc_start_o === 1'b1) adc_cnt++;
    task automatic end_of_test;
        if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Reserved codes run as the slowest setting
    function automatic int exp_period(input logic [3:0] code);
        return (code > 4'h8) ? 256 : (1 << code);
    endfunction
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] wd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= wd;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        d = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic pulse(input logic s, input logic [6:0] m);
        @(posedge clk_i);
        sreq <= s;
        wreq <= !s;
        wmask <= m;
        @(posedge clk_i);
        sreq <= 1'b0;
        wreq <= 1'b0;
    endtask
    task automatic gap(output int g);
        g = 0;
        repeat (2) do @(posedge clk_i); while (sys_tick_o !== 1'b1);
        do begin @(posedge clk_i); g++; end while (sys_tick_o !== 1'b1);
    endtask
    // Interrupt sources stay low across each two-write change
    task automatic setdiv(input logic [3:0] v);
        bus(1, 4'h4, 32'h80);
        bus(1, 4'h4, {25'h0, 3'h5, v});
    endtask
    task automatic sleepm(input logic [1:0] m, input logic [5:0] ex,
                          input logic [6:0] bad, good, input int lat, ads);
        st = adc_cnt;
        bus(1, 4'h8, {29'h0, m, 1'b1});
        pulse(1, 0);
        repeat (3) @(posedge clk_i);
        check("gates", en, ex);
        check("hold", cpu_hold_o, 1);
        if (bad != 0) begin
            pulse(0, bad);
            repeat (8) @(posedge clk_i);
            check("no_wake", cpu_hold_o, 1);
        end
        pulse(0, good);
        n = 0;
        do begin @(posedge clk_i); n++; end while (wake_o !== 1'b1 && n < 99);
        check("wake_lat", n, lat + 2);
        check("adc_start", adc_cnt - st, ads);
        repeat (2) @(posedge clk_i);
        check("gates_run", {cpu_hold_o, en}, 7'h3f);
    endtask
    initial begin
        #800000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        factory_trim_i = 8'($random(seed));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, 4'h0, 0);
        check("trim_rst", d, {24'h0, factory_trim_i});
        bus(0, 4'h4, 0);
        check("div_rst", d, 32'h3);
        // No memory writes run here; steps kept under 0x20
        t = 8'h78;
        for (i = 0; i < 4; i++) begin
            t = t + 8'({$random(seed)} % 8);
            bus(1, 4'h0, {24'h0, t});
            bus(0, 4'h0, 0);
            check("trim", d, {24'h0, t});
            check("trim_out", osc_trim_o, t);
        end
        bus(1, 4'h4, 32'h81);
        bus(1, 4'h4, 32'h5);
        bus(0, 4'h4, 0);
        check("div_lock", d, 32'h3);
        bus(1, 4'h4, 32'h80);
        bus(1, 4'h4, 32'h80);
        bus(1, 4'h4, 32'h5);
        bus(0, 4'h4, 0);
        check("div_expire", d, 32'h3);
        for (i = 0; i < 5; i++) begin
            c = (i < 4) ? 4'(2 * i) : 4'(9 + {$random(seed)} % 7);
            setdiv(c);
            bus(0, 4'h4, 0);
            check("div_set", d, {28'h0, c});
            gap(n);
            check("period", n, exp_period(c));
        end
        legacy_mode_i <= 1'b1;
        setdiv(4'h1);
        bus(0, 4'h4, 0);
        check("div_legacy", d[3:0], c);
        gap(n);
        check("period_legacy", n, 1);
        legacy_mode_i <= 1'b0;
        bus(1, 4'h8, 32'h0);
        pulse(1, 0);
        repeat (3) @(posedge clk_i);
        check("nop", {cpu_hold_o, en}, 7'h3f);
        sleepm(2'h0, 6'h0f, 7'h00, 7'h01, 4, 1);
        adc_enabled_i <= 1'b0;
        sleepm(2'h0, 6'h0f, 7'h00, 7'h01, 4, 0);
        adc_enabled_i <= 1'b1;
        sleepm(2'h1, 6'h05, 7'h01, 7'h02 << ({$random(seed)} % 5), 4, 1);
        sleepm(2'h2, 6'h00, 7'h29, 7'h40, 6, 0);
        sleepm(2'h2, 6'h00, 7'h00, 7'h12, 6, 0);
        bus(1, 4'h8, 32'h5);
        pulse(1, 0);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b1;
        div8_fuse_i <= 1'b0;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("rst_sleep", {cpu_hold_o, en}, 7'h3f);
        check("rst_trim", osc_trim_o, factory_trim_i);
        bus(0, 4'h4, 0);
        check("div_rst_plain", d, 32'h0);
        end_of_test;
    end
endmodule

// ---- dv/core_model.sv ----
// Core-side partner: issues sleep instructions and holds wake sources.
// Assumes the bench asks for one sleep or one wake at a time.
`timescale 1ns/100ps
module core_model (
    input  wire logic       clk_i,   // Master clock
    input  wire logic       sleep_i, // Bench asks for a sleep instruction
    input  wire logic       wake_i,  // Bench asks to raise masked sources
    input  wire logic [6:0] mask_i,  // Sources to raise
    input  wire logic       hold_i,  // Core held by the controller
    output logic            instr_o, // Sleep instruction pulse
    output logic      [6:0] src_o    // Wake source levels
);
    // ========================================================
    // Sleep issued only when asked, one cycle long
    always_ff @(posedge clk_i) begin
        instr_o <= sleep_i;
    end
    // ========================================================
    // Levels stay up until the core is released, else wake can be lost
    always_ff @(posedge clk_i) begin
        if (wake_i) begin
            src_o <= mask_i;
        end else if (hold_i !== 1'b1) begin
            src_o <= 7'h00;
        end
    end
endmodule
